// *** fault_reaction_stop_select.sv ***
// fault reaction stop selection and drive state sequencing
//
// Functional notes
// - hold signed 16-bit reaction code, defined values 0 to 2, kept across modes.
// - any reaction code outside 0..2 counts as disabled.
// - code applies only to alarm groups 80, 81, 85, 88 sub 0..7.
// - position/velocity modes, code 1 stops with profile deceleration, then fault.
// - homing code 0 alarm sequence, code 1 homing accel; torque code 0 alarm sequence.
// - torque modes, codes 1 and 2 stop with torque slope, then fault.
// - other alarms ignore the code and stop per alarm sequence, then fault.
// - decelerate at once on alarm and show fault reaction active meanwhile.
// - motor counts stopped when actual speed magnitude is 30 r/min or less.
// - on stop detection move from fault reaction active to fault.
`timescale 1ns/1ns
`include "stop_select_defs.svh"

module fault_reaction_stop_select (
  input  wire logic                         clock,          // drive clock
  input  wire logic                         arst_n,         // async reset
  input  wire stop_select_pkg::obj_req_t    obj_req,        // object access
  output logic                              obj_rsp_valid,  // read answer strobe
  output logic                              obj_rsp_err,    // unmapped index
  output logic [31:0]                       obj_rsp_rdata,  // read data
  input  wire stop_select_pkg::alarm_t      alarm,          // alarm event
  input  wire logic [7:0]                   op_mode,        // active mode
  input  wire logic signed [15:0]           actual_speed,   // r/min
  input  wire logic                         fault_reset,    // leave fault
  output stop_select_pkg::drive_state_t     drive_state,    // drive state
  output stop_select_pkg::decel_src_t       decel_src,      // chosen source
  output logic [31:0]                       decel_rate,     // chosen rate
  output logic [15:0]                       stop_sequence,  // alarm sequence
  output logic                              decel_active    // decelerating
);

  typedef struct packed {
    stop_select_pkg::drive_state_t st;
    stop_select_pkg::decel_src_t   src;
    logic [31:0]                   rate;
    logic [15:0]                   alarm_seq;
    logic signed [15:0]            react_sel;
    logic [31:0]                   profile_dec;
    logic [31:0]                   quick_dec;
    logic [31:0]                   torque_slope;
    logic [31:0]                   homing_acc;
    stop_select_pkg::obj_rsp_t     rsp;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  //////////////////////////////////////////////////////////////////////
  // alarm classification

  logic        comm_group;
  logic        comm_alarm;
  logic        code_ok;
  logic        posvel_mode;
  logic        homing_mode;
  logic        torque_mode;
  logic        stopped;
  logic [15:0] speed_mag;

  // communication alarm groups, each with sub-codes 0..7
  always_comb begin
    comm_group = 1'b0;
    case (alarm.main_code)
      `GRP_COMM_A,
      `GRP_COMM_B,
      `GRP_COMM_C,
      `GRP_COMM_D: begin
        comm_group = 1'b1;
      end
      default: begin
        comm_group = 1'b0;
      end
    endcase
    comm_alarm = comm_group && (alarm.sub_code <= `SUB_MAX);
  end

  // stored code outside the defined range means disabled
  always_comb begin
    code_ok = (state_r.react_sel >= 16'sh0000) && (state_r.react_sel <= 16'sh0002);
  end

  // mode classes; unknown mode codes fall back to the alarm sequence
  always_comb begin
    posvel_mode = 1'b0;
    homing_mode = 1'b0;
    torque_mode = 1'b0;
    case (op_mode)
      `MODE_PROF_POS,
      `MODE_CYC_POS,
      `MODE_INTERP_POS,
      `MODE_CYC_VEL,
      `MODE_PROF_VEL: begin
        posvel_mode = 1'b1;
      end
      `MODE_HOMING: begin
        homing_mode = 1'b1;
      end
      `MODE_CYC_TRQ,
      `MODE_PROF_TRQ: begin
        torque_mode = 1'b1;
      end
      default: begin
        posvel_mode = 1'b0;
      end
    endcase
  end

  // speed magnitude, so reverse rotation is judged alike
  always_comb begin
    if (actual_speed[15]) begin
      speed_mag = 16'(-actual_speed);
    end else begin
      speed_mag = actual_speed;
    end
    stopped = (speed_mag <= `STOP_SPEED_RPM);
  end

  //////////////////////////////////////////////////////////////////////
  // deceleration source selection

  stop_select_pkg::decel_src_t sel_src;

  always_comb begin
    sel_src = stop_select_pkg::SRC_ALARM_SEQ;
    if (comm_alarm && code_ok) begin
      case (state_r.react_sel[1:0])
        2'h1: begin
          if (posvel_mode) begin
            sel_src = stop_select_pkg::SRC_PROFILE_DEC;
          end else if (homing_mode) begin
            sel_src = stop_select_pkg::SRC_HOMING_ACC;
          end else if (torque_mode) begin
            sel_src = stop_select_pkg::SRC_TORQUE_SLOPE;
          end
        end
        2'h2: begin
          if (posvel_mode || homing_mode) begin
            sel_src = stop_select_pkg::SRC_QUICK_DEC;
          end else if (torque_mode) begin
            sel_src = stop_select_pkg::SRC_TORQUE_SLOPE;
          end
        end
        default: begin
          sel_src = stop_select_pkg::SRC_ALARM_SEQ;
        end
      endcase
    end
  end

  logic [31:0] sel_rate;

  always_comb begin
    case (sel_src)
      stop_select_pkg::SRC_PROFILE_DEC: begin
        sel_rate = state_r.profile_dec;
      end
      stop_select_pkg::SRC_QUICK_DEC: begin
        sel_rate = state_r.quick_dec;
      end
      stop_select_pkg::SRC_HOMING_ACC: begin
        sel_rate = state_r.homing_acc;
      end
      stop_select_pkg::SRC_TORQUE_SLOPE: begin
        sel_rate = state_r.torque_slope;
      end
      default: begin
        // the alarm sequence carries no rate of its own
        sel_rate = 32'h0000_0000;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // object read multiplexer

  logic [31:0] rd_word;
  logic        idx_mapped;

  always_comb begin
    rd_word    = 32'h0000_0000;
    idx_mapped = 1'b1;
    case (obj_req.index)
      `IDX_ALARM_SEQ: begin
        rd_word = {16'h0000, state_r.alarm_seq};
      end
      `IDX_REACT_SEL: begin
        rd_word = {{16{state_r.react_sel[15]}}, state_r.react_sel};
      end
      `IDX_PROFILE_DEC: begin
        rd_word = state_r.profile_dec;
      end
      `IDX_QUICK_DEC: begin
        rd_word = state_r.quick_dec;
      end
      `IDX_TORQUE_SLOPE: begin
        rd_word = state_r.torque_slope;
      end
      `IDX_HOMING_ACC: begin
        rd_word = state_r.homing_acc;
      end
      default: begin
        idx_mapped = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_nxt = state_r;
    state_nxt.rsp.valid = 1'b0;
    state_nxt.rsp.err = 1'b0;
    // object writes
    if (obj_req.wr) begin
      case (obj_req.index)
        `IDX_ALARM_SEQ: begin
          state_nxt.alarm_seq = obj_req.wdata[15:0];
        end
        `IDX_REACT_SEL: begin
          state_nxt.react_sel = obj_req.wdata[15:0];
        end
        `IDX_PROFILE_DEC: begin
          state_nxt.profile_dec = obj_req.wdata;
        end
        `IDX_QUICK_DEC: begin
          state_nxt.quick_dec = obj_req.wdata;
        end
        `IDX_TORQUE_SLOPE: begin
          state_nxt.torque_slope = obj_req.wdata;
        end
        `IDX_HOMING_ACC: begin
          state_nxt.homing_acc = obj_req.wdata;
        end
        default: begin
          state_nxt.rsp.err = 1'b1;
        end
      endcase
    end
    // object reads answer one cycle later; a read beside a write returns the old value
    if (obj_req.rd) begin
      state_nxt.rsp.valid = 1'b1;
      state_nxt.rsp.rdata = rd_word;
      if (!idx_mapped) begin
        state_nxt.rsp.err = 1'b1;
      end
    end
    // drive state sequencing
    case (state_r.st)
      stop_select_pkg::DRV_OPERATION: begin
        if (alarm.valid) begin
          state_nxt.st = stop_select_pkg::DRV_FAULT_REACTION;
          state_nxt.src = sel_src;
          state_nxt.rate = sel_rate;
        end
      end
      stop_select_pkg::DRV_FAULT_REACTION: begin
        // further alarms are refused here; the latched source stands
        if (stopped) begin
          state_nxt.st = stop_select_pkg::DRV_FAULT;
        end
      end
      stop_select_pkg::DRV_FAULT: begin
        if (fault_reset) begin
          state_nxt.st = stop_select_pkg::DRV_OPERATION;
        end
      end
      default: state_nxt.st = stop_select_pkg::DRV_FAULT;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r.st <= stop_select_pkg::DRV_OPERATION;
      state_r.src <= stop_select_pkg::SRC_ALARM_SEQ;
      state_r.rate <= `RST_RATE;
      state_r.alarm_seq <= `RST_ALARM_SEQ;
      state_r.react_sel <= `RST_REACT_SEL;
      state_r.profile_dec <= `RST_RATE;
      state_r.quick_dec <= `RST_RATE;
      state_r.torque_slope <= `RST_RATE;
      state_r.homing_acc <= `RST_RATE;
      state_r.rsp <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs

  assign obj_rsp_valid = state_r.rsp.valid;
  assign obj_rsp_err = state_r.rsp.err;
  assign obj_rsp_rdata = state_r.rsp.rdata;
  assign drive_state = state_r.st;
  assign decel_src = state_r.src;
  assign decel_rate = state_r.rate;
  assign stop_sequence = state_r.alarm_seq;
  assign decel_active = (state_r.st == stop_select_pkg::DRV_FAULT_REACTION);

endmodule

// *** fault_reaction_stop_select_props.sv ***
// assertion checker of the fault stop selector
`timescale 1ns/1ns
`include "stop_select_defs.svh"
module fault_reaction_stop_select_props (
  input wire logic                          clock,         // clk
  input wire logic                          arst_n,        // rst
  input wire stop_select_pkg::obj_req_t     obj_req,       // req
  input wire logic                          obj_rsp_valid, // ok
  input wire logic                          obj_rsp_err,   // err
  input wire logic [31:0]                   obj_rsp_rdata, // data
  input wire stop_select_pkg::alarm_t       alarm,         // alarm
  input wire logic [7:0]                    op_mode,       // mode
  input wire logic signed [15:0]            actual_speed,  // speed
  input wire logic                          fault_reset,   // reset
  input wire stop_select_pkg::drive_state_t drive_state,   // state
  input wire stop_select_pkg::decel_src_t   decel_src,     // source
  input wire logic [31:0]                   decel_rate,    // rate
  input wire logic [15:0]                   stop_sequence, // seq
  input wire logic                          decel_active   // active
);
  logic signed [15:0] code_r;
  logic               take, comm, low, bad;
  assign take = alarm.valid && drive_state == 2'h0;
  assign comm = alarm.sub_code <= `SUB_MAX && alarm.main_code inside {8'h50, 8'h51, 8'h55, 8'h58};
  assign low  = actual_speed <= 16'sh001E && actual_speed >= -16'sh001E;
  assign bad  = code_r[15] || code_r > 16'sh0002;
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n) code_r <= 16'h0000;
    else if (obj_req.wr && obj_req.index == `IDX_REACT_SEL) code_r <= obj_req.wdata[15:0];
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  AST_ACTIVE: assert property (decel_active == (drive_state == 2'h1)) else $error("active flag wrong");
  AST_ENTER: assert property (take |=> drive_state == 2'h1) else $error("no reaction state");
  AST_STOP: assert property (drive_state == 2'h1 && low |=> drive_state == 2'h2) else $error("no fault");
  AST_KEEP: assert property (drive_state == 2'h1 && !low |=> drive_state == 2'h1 && $stable(decel_src))
    else $error("left reaction early");
  AST_OTHER: assert property (take && !comm |=> decel_src == 3'h0) else $error("code used");
  AST_OFF: assert property (take && bad |=> decel_src == 3'h0) else $error("bad code used");
  AST_TORQUE: assert property (take && comm && !bad && code_r != 16'sh0000 && op_mode inside {8'h04, 8'h0A}
    |=> decel_src == 3'h4) else $error("no torque slope");
  AST_QUICK: assert property (take && comm && code_r == 16'sh0002
    && op_mode inside {8'h01, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09} |=> decel_src == 3'h2) else $error("no quick stop");
endmodule
bind fault_reaction_stop_select fault_reaction_stop_select_props chk (.*);

// *** fault_reaction_stop_select_tb.sv ***
// self-checking testbench of the fault stop selector
`timescale 1ns/1ns
module fault_reaction_stop_select_tb;
  logic                          clock, arst_n, fault_reset, obj_rsp_valid, obj_rsp_err, decel_active, e;
  stop_select_pkg::obj_req_t     obj_req;
  stop_select_pkg::alarm_t       alarm;
  stop_select_pkg::drive_state_t drive_state;
  stop_select_pkg::decel_src_t   decel_src;
  logic [31:0]                   obj_rsp_rdata, decel_rate, d;
  logic [15:0]                   stop_sequence;
  logic signed [15:0]            actual_speed;
  logic [7:0]                    op_mode;
  int                            errors, samples_checked;
  logic [15:0] ix [6] = '{16'h3510, 16'h605E, 16'h6084, 16'h6085, 16'h6087, 16'h609A};
  logic [31:0] wv [6] = '{32'h0000_8005, 32'h0000_FFFF, 32'h0000_1111, 32'h0000_2222, 32'h0000_4444, 32'h0000_3333};
  logic [31:0] rt [5] = '{32'h0000_0000, 32'h0000_1111, 32'h0000_2222, 32'h0000_3333, 32'h0000_4444};
  fault_reaction_stop_select dut (.clock, .arst_n, .obj_req, .obj_rsp_valid, .obj_rsp_err, .obj_rsp_rdata, .alarm,
    .op_mode, .actual_speed, .fault_reset, .drive_state, .decel_src, .decel_rate, .stop_sequence, .decel_active);
  fieldbus_master_model fbm (.clock, .obj_req, .rsp_ok(obj_rsp_valid), .rsp_err(obj_rsp_err), .rdata(obj_rsp_rdata));
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic rd(input logic [15:0] i, input logic [31:0] x, input logic xe);
    fbm.get(i, d, e);
    chk(d, x);
    chk(32'(e), 32'(xe));
  endtask
  task automatic hit(input logic [15:0] c, input logic [7:0] m, input logic [7:0] mc, input logic [3:0] s,
                     input logic [2:0] x);
    fbm.put(16'h605E, {16'h0000, c});
    op_mode = m;
    actual_speed = 16'sh001F;
    @(negedge clock) alarm = {1'b1, mc, s};
    @(negedge clock) alarm = {1'b1, 8'h50, 4'h0};
    chk(32'(decel_active), 32'h0000_0001);
    @(negedge clock) alarm = '0;
    chk(32'(drive_state), 32'h0000_0001);
    chk(32'(decel_src), 32'(x));
    chk(decel_rate, rt[x]);
    actual_speed = -16'sh001E;
    @(negedge clock) fault_reset = 1'b1;
    chk(32'(drive_state), 32'h0000_0002);
    @(negedge clock) fault_reset = 1'b0;
    chk(32'(drive_state), 32'h0000_0000);
    chk(32'(decel_active), 32'h0000_0000);
  endtask
  task automatic close_out();
    if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    #100000 errors++;
    close_out();
  end
  initial begin
    {arst_n, fault_reset, alarm, op_mode, actual_speed} = '0;
    repeat (5) @(negedge clock);
    arst_n = 1'b1;
    foreach (ix[k]) rd(ix[k], 32'h0000_0000, 1'b0);
    rd(16'h6000, 32'h0000_0000, 1'b1);
    foreach (ix[k]) fbm.put(ix[k], wv[k]);
    foreach (ix[k]) rd(ix[k], (k == 1) ? 32'hFFFF_FFFF : wv[k], 1'b0);
    chk(32'(stop_sequence), 32'h0000_8005);
    hit(16'h0001, 8'h01, 8'h50, 4'h7, 3'h1);
    hit(16'h0001, 8'h07, 8'h51, 4'h0, 3'h1);
    hit(16'h0002, 8'h09, 8'h55, 4'h3, 3'h2);
    hit(16'h0002, 8'h06, 8'h58, 4'h1, 3'h2);
    hit(16'h0001, 8'h06, 8'h50, 4'h2, 3'h3);
    hit(16'h0000, 8'h06, 8'h50, 4'h2, 3'h0);
    hit(16'h0000, 8'h04, 8'h51, 4'h2, 3'h0);
    hit(16'h0001, 8'h0A, 8'h51, 4'h4, 3'h4);
    hit(16'h0002, 8'h04, 8'h58, 4'h5, 3'h4);
    hit(16'h0000, 8'h08, 8'h55, 4'h6, 3'h0);
    hit(16'h0002, 8'h01, 8'h52, 4'h0, 3'h0);
    hit(16'h0002, 8'h01, 8'h50, 4'h8, 3'h0);
    hit(16'h0003, 8'h03, 8'h50, 4'h0, 3'h0);
    hit(16'hFFFF, 8'h08, 8'h50, 4'h0, 3'h0);
    close_out();
  end
endmodule

// *** fieldbus_master_model.sv ***
// fieldbus master model issuing object accesses
`timescale 1ns/1ns
module fieldbus_master_model (
  input  wire logic                 clock,   // clk
  output stop_select_pkg::obj_req_t obj_req, // req
  input  wire logic                 rsp_ok,  // ok
  input  wire logic                 rsp_err, // err
  input  wire logic [31:0]          rdata    // data
);
  initial obj_req = '0;
  task automatic put(input logic [15:0] i, input logic [31:0] v);
    @(negedge clock) obj_req = {2'b10, i, v};
    @(negedge clock) obj_req = {2'b00, ~i, ~v};
  endtask
  task automatic get(input logic [15:0] i, output logic [31:0] v, output logic e);
    @(negedge clock) obj_req = {2'b01, i, 32'h0000_0000};
    @(negedge clock) obj_req = {2'b00, ~i, 32'hFFFF_FFFF};
    v = (rsp_ok || rsp_err) ? rdata : 32'hxxxx_xxxx;
    e = rsp_err;
  endtask
endmodule

// *** stop_select_defs.svh ***
// object indexes, reset values and stop threshold for the fault stop selector
`ifndef STOP_SELECT_DEFS_SVH
`define STOP_SELECT_DEFS_SVH
`define IDX_ALARM_SEQ    16'h3510
`define IDX_REACT_SEL    16'h605E
`define IDX_PROFILE_DEC  16'h6084
`define IDX_QUICK_DEC    16'h6085
`define IDX_TORQUE_SLOPE 16'h6087
`define IDX_HOMING_ACC   16'h609A
`define RST_ALARM_SEQ    16'h0000
`define RST_REACT_SEL    16'h0000
`define RST_RATE         32'h0000_0000
`define STOP_SPEED_RPM   16'h001E
`define MODE_PROF_POS    8'h01
`define MODE_PROF_VEL    8'h03
`define MODE_PROF_TRQ    8'h04
`define MODE_HOMING      8'h06
`define MODE_INTERP_POS  8'h07
`define MODE_CYC_POS     8'h08
`define MODE_CYC_VEL     8'h09
`define MODE_CYC_TRQ     8'h0A
`define GRP_COMM_A       8'h50
`define GRP_COMM_B       8'h51
`define GRP_COMM_C       8'h55
`define GRP_COMM_D       8'h58
`define SUB_MAX          4'h7
`endif

// *** stop_select_pkg.sv ***
// types of the fault stop selector
package stop_select_pkg;
  typedef enum logic [1:0] {
    DRV_OPERATION,
    DRV_FAULT_REACTION,
    DRV_FAULT
  } drive_state_t;
  typedef enum logic [2:0] {
    SRC_ALARM_SEQ,
    SRC_PROFILE_DEC,
    SRC_QUICK_DEC,
    SRC_HOMING_ACC,
    SRC_TORQUE_SLOPE
  } decel_src_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] index;
    logic [31:0] wdata;
  } obj_req_t;
  typedef struct packed {
    logic        valid;
    logic        err;
    logic [31:0] rdata;
  } obj_rsp_t;
  typedef struct packed {
    logic        valid;
    logic [7:0]  main_code;
    logic [3:0]  sub_code;
  } alarm_t;
endpackage
